// ### dv/dac_control_word_decoder_tb.sv
`timescale 1ns/1ps
module dac_control_word_decoder_tb;
    import dac_ctrl_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PORT_W-1:0] channel_a_port;
    logic [PORT_W-1:0] conv_data;
    logic [PORT_W-1:0] prev_port = 10'h000;
    logic [PORT_W-1:0] word;
    logic control_write_strobe_n;
    logic prev_strobe = 1'b1;
    logic prev_rst = 1'b1;
    logic fall_d = 1'b0;
    power_mode_e power_mode;
    interp_mode_e interp_mode;
    logic [GAIN_W-1:0] gain_trim;
    logic [3:0] sel;
    int failures = 0;
    int num_checks = 0;
    int seed = 38447;
    logic [32:0] rd_q[$];
    logic [7:0] dec_q[$];

    always #4 core_clk = ~core_clk;

    dac_control_word_decoder u_dac_control_word_decoder (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .channel_a_port(channel_a_port),
        .control_write_strobe_n(control_write_strobe_n),
        .conv_data(conv_data), .power_mode(power_mode),
        .interp_mode(interp_mode), .gain_trim(gain_trim)
    );

    host_port_drv u_host_port_drv (
        .core_clk(core_clk), .channel_a_port(channel_a_port),
        .control_write_strobe_n(control_write_strobe_n)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_dec(input logic [PORT_W-1:0] w);
        logic [1:0] p;
        logic [1:0] m;
        p = w[9] ? 2'h2 : (w[8] ? 2'h0 : 2'h1);
        m = w[7] ? 2'h2 : (w[6] ? 2'h1 : 2'h0);
        return {w[5:2], m, p};
    endfunction : exp_dec

    task automatic results();
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [32:0] e,
                       input logic [32:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic chk_rd(input logic [32:0] e);
        chk("prdata", e, {pslverr, prdata});
    endtask : chk_rd

    task automatic chk_dec(input logic [7:0] e);
        chk("decode", 33'(e),
            33'({gain_trim, interp_mode, power_mode}));
    endtask : chk_dec

    task automatic chk_data(input logic [PORT_W-1:0] e);
        chk("conv_data", 33'(e), 33'(conv_data));
    endtask : chk_data

    // pready is polled, never assumed, so wait states would be honoured
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            failures++;
            results();
        end
        else
        begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    ////////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        if (!rst && psel && penable && pready && !pwrite)
            chk_rd(rd_q.pop_front());
        if (fall_d)
            chk_dec(dec_q.pop_front());
        if (!prev_rst && prev_strobe)
            chk_data(prev_port);
        fall_d <= !rst && prev_strobe && !control_write_strobe_n;
        prev_strobe <= rst | control_write_strobe_n;
        prev_port <= channel_a_port;
        prev_rst <= rst;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        results();
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(CFG_OFS, {1'b0, 32'h1});
        rd(WORD_OFS, {1'b0, 22'h0, CTRL_WORD_RST});
        rd(STATUS_OFS, {1'b0, 24'h0, exp_dec(CTRL_WORD_RST)});
        rd(COUNT_OFS, 33'h0);
        rd(8'h10, {1'b1, 32'h0});
        // every power and filter setting, back to back on even passes
        for (int i = 0; i < 16; i++)
        begin
            sel = 4'(i);
            word = {sel[0], sel[1], sel[3] & sel[2], sel[2] | sel[3],
                    4'($random(seed)), 2'($random(seed))};
            dec_q.push_back(exp_dec(word));
            u_host_port_drv.ctrl_write(word);
            if (sel[0])
                u_host_port_drv.traffic(3);
        end
        u_host_port_drv.traffic(4);
        rd(STATUS_OFS, {1'b0, 24'h0, exp_dec(word)});
        rd(COUNT_OFS, 33'd16);
        apb(1'b1, CFG_OFS, 32'h0);
        dec_q.push_back(exp_dec(word));
        u_host_port_drv.ctrl_write(word ^ 10'h200);
        u_host_port_drv.traffic(2);
        rd(COUNT_OFS, 33'd16);
        apb(1'b1, CFG_OFS, 32'h1);
        // second filter without the first: 4x plus sticky flag
        word = 10'h0bc;
        apb(1'b1, WORD_OFS, {22'h0, word});
        rd(STATUS_OFS, {1'b0, 23'h0, 1'b1, exp_dec(word)});
        apb(1'b1, STATUS_OFS, 32'h100);
        rd(STATUS_OFS, {1'b0, 24'h0, exp_dec(word)});
        rd(WORD_OFS, {1'b0, 22'h0, word});
        results();
    end
endmodule : dac_control_word_decoder_tb

// ### dv/host_port_drv.sv
`timescale 1ns/1ps
module host_port_drv (
    input wire logic core_clk,
    output logic [dac_ctrl_pkg::PORT_W-1:0] channel_a_port,
    output logic control_write_strobe_n
);
    int seed = 38447;

    initial
    begin
        channel_a_port = 10'h000;
        control_write_strobe_n = 1'b1;
    end

    // data traffic changes every cycle so a stale capture stands out
    task automatic traffic(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            channel_a_port <= 10'($random(seed));
            control_write_strobe_n <= 1'b1;
        end
    endtask : traffic

    // strobe high for one cycle, then low with the word on the port;
    // callers keep bit 7 set only together with bit 6
    task automatic ctrl_write(input logic [9:0] w);
        @(posedge core_clk);
        control_write_strobe_n <= 1'b1;
        channel_a_port <= 10'($random(seed));
        @(posedge core_clk);
        channel_a_port <= w;
        control_write_strobe_n <= 1'b0;
    endtask : ctrl_write
endmodule : host_port_drv

// ### verilog/dac_control_word_decoder.sv
`timescale 1ns/1ps
module dac_control_word_decoder #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dac_ctrl_pkg::PORT_W-1:0] channel_a_port,
    input wire logic control_write_strobe_n,
    output logic [dac_ctrl_pkg::PORT_W-1:0] conv_data,
    output dac_ctrl_pkg::power_mode_e power_mode,
    output dac_ctrl_pkg::interp_mode_e interp_mode,
    output logic [dac_ctrl_pkg::GAIN_W-1:0] gain_trim
);
    import dac_ctrl_pkg::*;

    if (ADDR_W < 4 || ADDR_W > 32)
    begin : g_addr_w_check
        $error("ADDR_W must lie between 4 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe edge and control word capture

    logic strobe_n_prev_r;
    logic strobe_en_r;
    logic [PORT_W-1:0] ctrl_word_r;
    logic [PORT_W-1:0] ctrl_word_nxt;
    logic [PORT_W-1:0] conv_data_r;
    logic bad_filter_r;
    logic bad_filter_nxt;
    logic [15:0] count_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;

    // inputs are synchronous, so one stage of history finds the edge
    wire strobe_fall = strobe_n_prev_r & ~control_write_strobe_n;
    wire hw_load = strobe_fall & strobe_en_r;

    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire [ADDR_W-1:0] cfg_a = ADDR_W'(CFG_OFS);
    wire [ADDR_W-1:0] word_a = ADDR_W'(WORD_OFS);
    wire [ADDR_W-1:0] status_a = ADDR_W'(STATUS_OFS);
    wire [ADDR_W-1:0] count_a = ADDR_W'(COUNT_OFS);
    wire hit_cfg = paddr == cfg_a;
    wire hit_word = paddr == word_a;
    wire hit_status = paddr == status_a;
    wire hit_count = paddr == count_a;
    wire mapped = hit_cfg | hit_word | hit_status | hit_count;
    wire wr_ok = access_ph & pwrite & mapped;
    wire wr_cfg = wr_ok & hit_cfg;
    wire sw_load = wr_ok & hit_word;
    wire bad_clr = wr_ok & hit_status & pwdata[ST_BAD_FILTER_BIT];

    // the pin strobe wins over a same-cycle software load of the word
    assign ctrl_word_nxt = hw_load ? channel_a_port
                         : sw_load ? pwdata[PORT_W-1:0]
                         : ctrl_word_r;

    // 4x without the first filter bit is a host fault; set beats clear
    wire bad_set = (hw_load | sw_load)
                 & ctrl_word_nxt[SECOND_FILTER_BIT]
                 & ~ctrl_word_nxt[FIRST_FILTER_BIT];
    assign bad_filter_nxt = bad_set | (bad_filter_r & ~bad_clr);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            strobe_n_prev_r <= 1'b1;
            ctrl_word_r <= CTRL_WORD_RST;
            bad_filter_r <= 1'b0;
            count_r <= COUNT_RST;
        end
        else
        begin
            strobe_n_prev_r <= control_write_strobe_n;
            ctrl_word_r <= ctrl_word_nxt;
            bad_filter_r <= bad_filter_nxt;
            count_r <= count_r + 16'(hw_load);
        end
    end

    // data traffic is passed on only while no control write is in progress
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            conv_data_r <= '0;
        end
        else if (control_write_strobe_n)
        begin
            conv_data_r <= channel_a_port;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode of the word in force

    assign power_mode = power_of(ctrl_word_r);
    assign interp_mode = interp_of(ctrl_word_r);
    assign gain_trim = ctrl_word_r[GAIN_MSB:GAIN_LSB];
    assign conv_data = conv_data_r;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: read data is fetched in setup, so no wait states

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            strobe_en_r <= CFG_STROBE_EN_RST;
        end
        else if (wr_cfg)
        begin
            strobe_en_r <= pwdata[CFG_STROBE_EN_BIT];
        end
    end

    always_comb
    begin
        rd_mux = '0;
        if (hit_cfg)
        begin
            rd_mux[CFG_STROBE_EN_BIT] = strobe_en_r;
        end
        if (hit_word)
        begin
            rd_mux[PORT_W-1:0] = ctrl_word_r;
        end
        if (hit_status)
        begin
            rd_mux[ST_POWER_LSB +: 2] = power_mode;
            rd_mux[ST_INTERP_LSB +: 2] = interp_mode;
            rd_mux[ST_GAIN_LSB +: GAIN_W] = gain_trim;
            rd_mux[ST_BAD_FILTER_BIT] = bad_filter_r;
        end
        if (hit_count)
        begin
            rd_mux[15:0] = count_r;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            prdata_r <= '0;
        end
        else if (setup_ph & ~pwrite)
        begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_hw_fall;
        strobe_n_prev_r && !control_write_strobe_n && strobe_en_r;
    endsequence

    sequence s_quiet;
        !hw_load && !sw_load;
    endsequence

    property p_capture;
        @(posedge core_clk) disable iff (rst)
        s_hw_fall |=> ctrl_word_r == $past(channel_a_port);
    endproperty
    a_capture: assert property (p_capture)
        else $error("control word not captured on strobe fall");

    property p_hold;
        @(posedge core_clk) disable iff (rst)
        s_quiet ##1 s_quiet |=> $stable(power_mode) && $stable(interp_mode)
            && $stable(gain_trim);
    endproperty
    a_hold: assert property (p_hold)
        else $error("settings changed without a control write");

    property p_power_down;
        @(posedge core_clk) disable iff (rst)
        s_hw_fall ##0 channel_a_port[POWER_DOWN_BIT]
            |=> power_mode == PWR_DOWN;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down bit did not force power-down");

    property p_standby;
        @(posedge core_clk) disable iff (rst)
        s_hw_fall ##0 (channel_a_port[POWER_DOWN_BIT:CONV_ENABLE_BIT] == 2'b00)
            |=> power_mode == PWR_STANDBY;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby not entered");

    property p_normal;
        @(posedge core_clk) disable iff (rst)
        s_hw_fall ##0 (channel_a_port[POWER_DOWN_BIT:CONV_ENABLE_BIT] == 2'b01)
            |=> power_mode == PWR_NORMAL;
    endproperty
    a_normal: assert property (p_normal)
        else $error("converter not powered up");

    property p_interp_low;
        @(posedge core_clk) disable iff (rst)
        !ctrl_word_r[SECOND_FILTER_BIT] |-> interp_mode
            == (ctrl_word_r[FIRST_FILTER_BIT] ? INTERP_2X : INTERP_1X);
    endproperty
    a_interp_low: assert property (p_interp_low)
        else $error("first filter bit decoded wrongly");

    property p_interp_4x;
        @(posedge core_clk) disable iff (rst)
        s_hw_fall ##0 channel_a_port[SECOND_FILTER_BIT] |=>
            interp_mode == INTERP_4X
            && (bad_filter_r == !$past(channel_a_port[FIRST_FILTER_BIT])
                || $past(bad_filter_r));
    endproperty
    a_interp_4x: assert property (p_interp_4x)
        else $error("4x mode or filter fault flag wrong");

    property p_gain;
        @(posedge core_clk) disable iff (rst)
        s_hw_fall |=> gain_trim == $past(channel_a_port[GAIN_MSB:GAIN_LSB]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain trim not taken from bits 5..2");

    property p_data;
        @(posedge core_clk) disable iff (rst)
        control_write_strobe_n |=> conv_data == $past(channel_a_port);
    endproperty
    a_data: assert property (p_data)
        else $error("conversion data not passed in bit order");

    property p_data_hold;
        @(posedge core_clk) disable iff (rst)
        !control_write_strobe_n |=> $stable(conv_data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("conversion data changed during a control write");

    property p_refused;
        @(posedge core_clk) disable iff (rst)
        strobe_fall && !strobe_en_r && !sw_load |=> $stable(ctrl_word_r);
    endproperty
    a_refused: assert property (p_refused)
        else $error("disabled strobe changed the control word");

    property p_sw_load;
        @(posedge core_clk) disable iff (rst)
        sw_load && !hw_load |=> ctrl_word_r == $past(pwdata[PORT_W-1:0]);
    endproperty
    a_sw_load: assert property (p_sw_load)
        else $error("software write did not load the control word");

    property p_bad_sw;
        @(posedge core_clk) disable iff (rst)
        sw_load && !hw_load && pwdata[SECOND_FILTER_BIT]
            && !pwdata[FIRST_FILTER_BIT] |=> bad_filter_r
            && interp_mode == INTERP_4X;
    endproperty
    a_bad_sw: assert property (p_bad_sw)
        else $error("4x word without first filter bit not flagged");

    property p_bad_sticky;
        @(posedge core_clk) disable iff (rst)
        bad_filter_r && !bad_clr |=> bad_filter_r;
    endproperty
    a_bad_sticky: assert property (p_bad_sticky)
        else $error("filter fault flag dropped without a clear");

    property p_count;
        @(posedge core_clk) disable iff (rst)
        hw_load |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_count: assert property (p_count)
        else $error("strobe capture not counted");

    property p_count_hold;
        @(posedge core_clk) disable iff (rst)
        !hw_load |=> $stable(count_r);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("capture count moved without a capture");

    property p_read_word;
        @(posedge core_clk) disable iff (rst)
        setup_ph && !pwrite && hit_word
            |=> prdata == 32'($past(ctrl_word_r));
    endproperty
    a_read_word: assert property (p_read_word)
        else $error("word read back differs from the word in force");

endmodule : dac_control_word_decoder

// ### verilog/dac_ctrl_pkg.sv
// Summary of operation
// - power-down bit (port bit 9) set forces full power-down, enable ignored
// - power-down clear and enable bit (bit 8) clear gives standby
// - power-down clear and enable bit set runs the converter normally
// - first filter bit (bit 6): 0 no interpolation, 1 gives 2x if bit 7 low
// - second filter bit (bit 7) selects 4x; host must also set bit 6
// - gain trim is port bits 5 down to 2, bit 5 most significant
// - port carries data bit 9 MSB to bit 0 LSB, shared with control word
// - host drives word and pulses low strobe; word captured on falling edge
package dac_ctrl_pkg;

    localparam int PORT_W = 10;

    // control word field positions on the channel a port
    localparam int POWER_DOWN_BIT = 9;
    localparam int CONV_ENABLE_BIT = 8;
    localparam int SECOND_FILTER_BIT = 7;
    localparam int FIRST_FILTER_BIT = 6;
    localparam int GAIN_MSB = 5;
    localparam int GAIN_LSB = 2;
    localparam int GAIN_W = GAIN_MSB - GAIN_LSB + 1;

    // word in force after reset: converter powered down
    localparam logic [PORT_W-1:0] CTRL_WORD_RST = 10'h200;

    // register byte offsets
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] WORD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0c;

    // cfg fields
    localparam int CFG_STROBE_EN_BIT = 0;
    localparam logic CFG_STROBE_EN_RST = 1'b1;

    // status fields
    localparam int ST_POWER_LSB = 0;
    localparam int ST_INTERP_LSB = 2;
    localparam int ST_GAIN_LSB = 4;
    localparam int ST_BAD_FILTER_BIT = 8;

    localparam logic [15:0] COUNT_RST = 16'h0000;

    typedef enum logic [1:0] {PWR_NORMAL, PWR_STANDBY, PWR_DOWN} power_mode_e;
    typedef enum logic [1:0] {INTERP_1X, INTERP_2X, INTERP_4X} interp_mode_e;

    function automatic power_mode_e power_of(input logic [PORT_W-1:0] w);
        power_mode_e m;
        m = PWR_DOWN;
        if (!w[POWER_DOWN_BIT])
        begin
            m = w[CONV_ENABLE_BIT] ? PWR_NORMAL : PWR_STANDBY;
        end
        return m;
    endfunction : power_of

    function automatic interp_mode_e interp_of(input logic [PORT_W-1:0] w);
        interp_mode_e m;
        m = INTERP_1X;
        if (w[SECOND_FILTER_BIT])
        begin
            m = INTERP_4X;
        end
        else if (w[FIRST_FILTER_BIT])
        begin
            m = INTERP_2X;
        end
        return m;
    endfunction : interp_of

endpackage : dac_ctrl_pkg
